// ---- inc/sram_port_params.svh ----
// constants of the pipelined burst sram port: widths, sizes, lane layout
// assumes inclusion by bare name from the package and design files
`ifndef SRAM_PORT_PARAMS_SVH
`define SRAM_PORT_PARAMS_SVH

`define SP_ADDR_W    15
`define SP_DATA_W    32
`define SP_LANES     4
`define SP_LANE_W    8
`define SP_CNT_W     2
`define SP_WORDS     32768
`define SP_BUF_DEPTH 2
`define SP_ALL_LANES 4'hf
`define SP_NO_LANES  4'h0
`define SP_CNT_ZERO  2'h0
`define SP_CNT_ONE   2'h1

`endif

// ---- inc/sram_port_pkg.sv ----
// types shared by the pipelined burst sram port files
// assumes sram_port_params.svh is on the include path
`include "sram_port_params.svh"

package sram_port_pkg;
   typedef logic [`SP_ADDR_W-1:0] word_addr_t;
   typedef logic [`SP_DATA_W-1:0] data_word_t;
   typedef logic [`SP_LANES-1:0]  lane_mask_t;
   typedef logic [`SP_CNT_W-1:0]  burst_cnt_t;
   typedef enum logic {
      ORDER_LINEAR,
      ORDER_INTERLEAVED
   } burst_order_t;
endpackage : sram_port_pkg

// ---- rtl/sram_port_pair_buf.sv ----
// two-entry buffer with valid and ready on both sides for read data
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
`include "sram_port_params.svh"

module sram_port_pair_buf (
   // clock and reset
   input  wire logic                     i_clk_sys,
   input  wire logic                     i_srst,
   // filling side
   input  wire logic                     i_in_valid,
   output logic                          o_in_ready,
   input  wire sram_port_pkg::data_word_t i_in_data,
   // draining side
   output logic                          o_out_valid,
   input  wire logic                     i_out_ready,
   output sram_port_pkg::data_word_t     o_out_data
);
   import sram_port_pkg::*;

   logic [1:0] count;
   data_word_t data0;
   data_word_t data1;
   wire        push;
   wire        pop;
   data_word_t next_data0;
   data_word_t next_data1;
   logic [1:0] next_count;

   // handshake decode
   assign o_in_ready  = (count != 2'h2);
   assign o_out_valid = (count != 2'h0);
   assign o_out_data  = data0;
   assign push        = i_in_valid & o_in_ready;
   assign pop         = o_out_valid & i_out_ready;

   // next contents: head shifts on pop, new word lands behind the survivor
   assign next_data0 = (push && (count == 2'h0 || (pop && count == 2'h1))) ? i_in_data :
                       pop ? data1 : data0;
   assign next_data1 = (push && ((!pop && count == 2'h1) || (pop && count == 2'h2))) ? i_in_data : data1;
   assign next_count = count + {1'b0, push} - {1'b0, pop};

   // storage and occupancy
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         count <= 2'h0;
      end else begin
         count <= next_count;
      end
      data0 <= next_data0;
      data1 <= next_data1;
   end
endmodule : sram_port_pair_buf

// ---- rtl/sram_burst_port.sv ----
// pipelined burst sram port: address capture, burst counter, byte-lane writes, read pipeline
// assumes synchronous pins on i_clk_sys; the data pin is split into in, out and enable
`timescale 1ns/1ps
`include "sram_port_params.svh"

module sram_burst_port (
   // clock and reset
   input  wire logic                      i_clk_sys,
   input  wire logic                      i_srst,
   // address and strobes
   input  wire sram_port_pkg::word_addr_t i_word_address,
   input  wire logic                      i_addr_strobe_ctrl_n,
   input  wire logic                      i_addr_strobe_proc_n,
   input  wire logic                      i_burst_step_n,
   input  wire logic                      i_burst_order_select,
   // selects
   input  wire logic                      i_primary_select_n,
   input  wire logic                      i_select_high,
   input  wire logic                      i_select_low_n,
   // writes
   input  wire logic                      i_all_lanes_write_n,
   input  wire logic                      i_lane_write_gate_n,
   input  wire sram_port_pkg::lane_mask_t i_lane_write_n,
   // output control and sleep
   input  wire logic                      i_output_enable_n,
   input  wire logic                      i_sleep_request,
   output logic                           o_sleeping,
   // data bus and read handshake
   input  wire sram_port_pkg::data_word_t i_data_bus,
   output sram_port_pkg::data_word_t      o_data_bus,
   output logic                           o_data_bus_oe,
   output logic                           o_rd_valid,
   input  wire logic                      i_rd_ready
);
   import sram_port_pkg::*;

   data_word_t   mem [0:`SP_WORDS-1];
   word_addr_t   base;
   burst_cnt_t   cnt;
   logic         active;
   logic         pend;
   logic         wr_pend;
   word_addr_t   wr_addr;
   data_word_t   wr_data;
   lane_mask_t   wr_lanes;
   wire          sel;
   wire          cap_ctrl;
   wire          cap_proc;
   wire          capture;
   wire          start;
   lane_mask_t   lanes_req;
   wire          lanes_any;
   wire          wr_go;
   wire          do_step;
   wire          buf_in_ready;
   wire          buf_out_valid;
   burst_cnt_t   cur_low;
   word_addr_t   cur_addr;
   burst_order_t order;
   data_word_t   rd_word;

   // select and capture decode
   assign sel      = i_select_high & ~i_select_low_n & ~i_primary_select_n;
   assign cap_ctrl = ~i_addr_strobe_ctrl_n;
   assign cap_proc = ~i_addr_strobe_proc_n & ~i_primary_select_n;
   assign capture  = (cap_ctrl | cap_proc) & ~i_sleep_request;
   assign start    = capture & sel;

   // write lane decode: all-lanes beats gated lanes, processor strobe blocks lanes
   assign lanes_req = ~i_all_lanes_write_n ? `SP_ALL_LANES :
                      (~i_lane_write_gate_n & i_addr_strobe_proc_n) ? ~i_lane_write_n
                      : `SP_NO_LANES;
   assign lanes_any = |lanes_req;
   assign wr_go     = active & ~capture & ~i_sleep_request & lanes_any;

   // burst address: counter folded into the low bits by order
   assign order    = i_burst_order_select ? ORDER_INTERLEAVED : ORDER_LINEAR;
   assign cur_low  = (order == ORDER_INTERLEAVED) ? (base[1:0] ^ cnt)
                                                  : burst_cnt_t'(base[1:0] + cnt);
   assign cur_addr = {base[`SP_ADDR_W-1:2], cur_low};
   assign do_step  = active & ~capture & ~i_sleep_request & ~i_burst_step_n
                     & (~pend | buf_in_ready);

   // array read for the pending beat
   assign rd_word = mem[cur_addr];

   // control, burst counter and read request
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         active <= 1'b0;
         pend   <= 1'b0;
         cnt    <= `SP_CNT_ZERO;
         base   <= '0;
      end else if (capture) begin
         active <= sel;
         pend   <= sel & ~lanes_any;
         cnt    <= `SP_CNT_ZERO;
         base   <= i_word_address;
      end else if (i_sleep_request) begin
         active <= 1'b0;
         pend   <= 1'b0;
      end else begin
         if (do_step) begin
            cnt <= cnt + `SP_CNT_ONE;
         end
         pend <= (pend & ~buf_in_ready) | (do_step & ~lanes_any);
      end
   end

   // registered write request, data, address and lanes
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         wr_pend <= 1'b0;
      end else begin
         wr_pend <= wr_go;
      end
      wr_addr  <= cur_addr;
      wr_data  <= i_data_bus;
      wr_lanes <= lanes_req;
   end

   // self-timed array write, one process so the array has a single driver
   always_ff @(posedge i_clk_sys) begin
      if (wr_pend) begin
         for (int g = 0; g < `SP_LANES; g++) begin
            if (wr_lanes[g]) begin
               mem[wr_addr][g*`SP_LANE_W +: `SP_LANE_W] <= wr_data[g*`SP_LANE_W +: `SP_LANE_W];
            end
         end
      end
   end

   // output pipeline register and stall buffer
   sram_port_pair_buf u_buf (
      .i_clk_sys   (i_clk_sys),
      .i_srst      (i_srst),
      .i_in_valid  (pend & active),
      .o_in_ready  (buf_in_ready),
      .i_in_data   (rd_word),
      .o_out_valid (buf_out_valid),
      .i_out_ready (i_rd_ready),
      .o_out_data  (o_data_bus)
   );

   // output drivers: released with active, gated at once by enable and sleep
   assign o_rd_valid    = buf_out_valid & active;
   assign o_data_bus_oe = active & buf_out_valid & ~wr_pend
                          & ~i_output_enable_n & ~i_sleep_request;
   assign o_sleeping    = i_sleep_request;

   // checks on the port's own behaviour
   property p_capture;
      @(posedge i_clk_sys) disable iff (i_srst)
      start |=> (base == $past(i_word_address)) && (cnt == `SP_CNT_ZERO) && active;
   endproperty
   a_capture: assert property (p_capture) else $error("address not captured on strobe");

   property p_proc_gated;
      @(posedge i_clk_sys) disable iff (i_srst)
      (i_addr_strobe_ctrl_n && i_primary_select_n) |=> base == $past(base);
   endproperty
   a_proc_gated: assert property (p_proc_gated) else $error("gated strobe loaded an address");

   property p_step;
      @(posedge i_clk_sys) disable iff (i_srst)
      do_step |=> cnt == $past(cnt) + `SP_CNT_ONE;
   endproperty
   a_step: assert property (p_step) else $error("burst counter did not step");

   property p_hold;
      @(posedge i_clk_sys) disable iff (i_srst)
      (i_burst_step_n && !capture) |=> cnt == $past(cnt);
   endproperty
   a_hold: assert property (p_hold) else $error("burst counter moved while held");

   property p_first_beat;
      @(posedge i_clk_sys) disable iff (i_srst)
      (start && !lanes_any) ##1 (buf_in_ready && !capture && !i_sleep_request) |=> buf_out_valid;
   endproperty
   a_first_beat: assert property (p_first_beat) else $error("first beat missing after pipeline");

   property p_interleave;
      @(posedge i_clk_sys) disable iff (i_srst)
      (do_step && cnt == `SP_CNT_ZERO && i_burst_order_select) |=> cur_addr[1:0] == (base[1:0] ^ `SP_CNT_ONE);
   endproperty
   a_interleave: assert property (p_interleave) else $error("interleaved order wrong");

   property p_all_lanes;
      @(posedge i_clk_sys) disable iff (i_srst)
      (wr_go && !i_all_lanes_write_n) |=> wr_pend && (wr_lanes == `SP_ALL_LANES);
   endproperty
   a_all_lanes: assert property (p_all_lanes) else $error("all-lanes write not full");

   property p_gate;
      @(posedge i_clk_sys) disable iff (i_srst)
      (i_lane_write_gate_n && i_all_lanes_write_n) |=> !wr_pend;
   endproperty
   a_gate: assert property (p_gate) else $error("gated lane write reached array");

   property p_deselect;
      @(posedge i_clk_sys) disable iff (i_srst)
      (capture && !sel) |=> !active && !o_data_bus_oe;
   endproperty
   a_deselect: assert property (p_deselect) else $error("outputs not released after deselect");

   property p_sleep;
      @(posedge i_clk_sys) disable iff (i_srst)
      i_sleep_request |=> !active && !pend;
   endproperty
   a_sleep: assert property (p_sleep) else $error("port active during sleep");
endmodule : sram_burst_port

// ---- verif/sram_ctrl_model.sv ----
// controller-side model: read receiver with stall control and data wire resolution
// assumes the bench drives write data and stall at falling edges
`timescale 1ns/1ps
module sram_ctrl_model (
   // clock
   input  wire logic                      i_clk_sys,
   // bench controls
   input  wire logic                      i_stall,
   input  wire logic                      i_drive,
   input  wire sram_port_pkg::data_word_t i_wr_data,
   // port side
   input  wire sram_port_pkg::data_word_t i_dout,
   input  wire logic                      i_oe,
   output logic                           o_rd_ready,
   output sram_port_pkg::data_word_t      o_wire
);
   import sram_port_pkg::*;
   data_word_t last;
   // receiver takes every beat unless stalled
   assign o_rd_ready = ~i_stall;
   // released wire shows a pattern that flips each cycle
   assign o_wire = i_oe ? i_dout : (i_drive ? i_wr_data : ~last);
   always_ff @(posedge i_clk_sys) begin
      last <= o_wire;
   end
endmodule : sram_ctrl_model

// ---- verif/sram_burst_port_bench.sv ----
// self-checking bench of the burst sram port with a scoreboard of read beats
// assumes the port and the controller model are compiled before it
`timescale 1ns/1ps
module sram_burst_port_bench;
   import sram_port_pkg::*;
   logic       clk = 0, srst = 1, ctrl_n = 1, proc_n = 1, step_n = 1, order = 0, prim_n = 0, sel_hi = 1;
   logic       sel_lo_n = 0, all_n = 1, gate_n = 1, oe_n = 0, sleep = 0, stall = 0, drive = 0;
   logic       sleeping, oe, rd_valid, rd_ready;
   lane_mask_t lane_n = 4'hf;
   word_addr_t addr = 15'h0000;
   data_word_t wdata = 32'h0000_0000, dout, wire_v, mem [word_addr_t], exp_q [$];
   int         num_errors = 0, cmp_count = 0;
   word_addr_t b;

   sram_burst_port i_sram_burst_port (.i_clk_sys(clk), .i_srst(srst), .i_word_address(addr),
      .i_addr_strobe_ctrl_n(ctrl_n), .i_addr_strobe_proc_n(proc_n), .i_burst_step_n(step_n),
      .i_burst_order_select(order), .i_primary_select_n(prim_n), .i_select_high(sel_hi),
      .i_select_low_n(sel_lo_n), .i_all_lanes_write_n(all_n), .i_lane_write_gate_n(gate_n),
      .i_lane_write_n(lane_n), .i_output_enable_n(oe_n), .i_sleep_request(sleep), .o_sleeping(sleeping),
      .i_data_bus(wire_v), .o_data_bus(dout), .o_data_bus_oe(oe), .o_rd_valid(rd_valid), .i_rd_ready(rd_ready));
   sram_ctrl_model i_sram_ctrl_model (.i_clk_sys(clk), .i_stall(stall), .i_drive(drive), .i_wr_data(wdata),
      .i_dout(dout), .i_oe(oe), .o_rd_ready(rd_ready), .o_wire(wire_v));

   initial begin
      forever #50 clk = ~clk;
   end

   task automatic print_verdict();
      if (num_errors == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : print_verdict

   task automatic chk(string n, data_word_t e, data_word_t s);
      cmp_count++;
      if (s !== e) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask : chk

   // burst address of beat k, interleaved or linear
   function automatic word_addr_t beat(word_addr_t a, int k);
      beat = {a[14:2], order ? a[1:0] ^ 2'(k) : a[1:0] + 2'(k)};
   endfunction : beat

   task automatic capture(word_addr_t a, bit proc, bit sel);
      @(negedge clk);
      addr = a;
      sel_hi = sel;
      if (proc) proc_n = 0;
      else ctrl_n = 0;
      @(negedge clk);
      {ctrl_n, proc_n, sel_hi} = 3'b111;
   endtask : capture

   // four beats written while stepping; lane writes lose to the all-lanes write
   task automatic wr_burst(word_addr_t a);
      @(negedge clk);
      {addr, ctrl_n, all_n, step_n, gate_n, drive} = {a, 5'b00001}; // lanes active at capture: no read starts
      lane_n = 4'($urandom);
      for (int k = 0; k < 4; k++) begin
         @(negedge clk);
         ctrl_n = 1;
         wdata = $urandom;
         mem[beat(a, k)] = wdata;
      end
      @(negedge clk);
      {all_n, step_n, gate_n, drive, lane_n} = 8'hef;
   endtask : wr_burst

   task automatic lane_wr(word_addr_t a, logic g, lane_mask_t m);
      exp_q.push_back(mem[a]);
      capture(a, 0, 1);
      {gate_n, lane_n, drive} = {g, m, 1'b1};
      wdata = $urandom;
      for (int j = 0; j < 4; j++) if (!g && !m[j]) mem[a][8*j+:8] = wdata[8*j+:8];
      @(negedge clk);
      {gate_n, lane_n, drive} = 6'h3e;
   endtask : lane_wr

   task automatic drain();
      for (int i = 0; i < 40 && exp_q.size() > 0; i++) @(negedge clk);
      repeat (4) @(negedge clk);
      if (exp_q.size() != 0) begin
         num_errors++;
         $display("mismatch drain expected 0 seen %0d", exp_q.size());
         print_verdict();
      end
   endtask : drain

   // capture then three steps, optionally holding the counter once
   task automatic rd_burst(word_addr_t a, bit proc, bit hold);
      for (int k = 0; k < 4; k++) exp_q.push_back(mem[beat(a, k)]);
      capture(a, proc, 1);
      step_n = 0;
      @(negedge clk);
      step_n = hold;
      @(negedge clk);
      step_n = 0;
      repeat (hold ? 2 : 1) @(negedge clk);
      step_n = 1;
      drain();
   endtask : rd_burst

   // scoreboard: every accepted beat meets the oldest note
   always @(posedge clk) begin
      if (!srst && rd_valid === 1'b1 && rd_ready) begin
         if (exp_q.size() == 0) chk("rd_extra", 32'h0000_0000, dout);
         else chk("rd_data", exp_q.pop_front(), dout);
      end
   end

   initial begin
      void'($urandom(32'h451261a5));
      repeat (3) @(negedge clk);
      srst = 0;
      for (int m = 0; m < 2; m++) begin
         order = m[0];
         b = 15'($urandom) & 15'h7ffc; // group-aligned so every burst stays in the written group
         wr_burst(b);
         rd_burst(b + 15'(m + 1), 0, 0);
         rd_burst(b + 15'h0002, 1, 1);
         prim_n = 1;
         capture(b + 15'h0001, 1, 1);
         prim_n = 0;
         lane_wr(b, 0, lane_n ^ 4'($urandom));
         lane_wr(b, 1, 4'h0);
         rd_burst(b, 0, 0);
         capture(b, 0, 0);
         drain();
      end
      // two stalled captures fill the buffer, then drain
      stall = 1;
      exp_q.push_back(mem[b]);
      exp_q.push_back(mem[b + 15'h0001]);
      capture(b, 0, 1);
      capture(b + 15'h0001, 0, 1);
      repeat (3) @(negedge clk);
      chk("oe", 32'h0000_0001, {31'h0, oe});
      oe_n = 1;
      #1 chk("oe", 32'h0000_0000, {31'h0, oe});
      oe_n = 0;
      sleep = 1;
      #1 chk("sleeping", 32'h0000_0001, {31'h0, sleeping});
      chk("oe", 32'h0000_0000, {31'h0, oe});
      sleep = 0;
      stall = 0;
      drain();
      sleep = 1;
      #1 chk("sleeping", 32'h0000_0001, {31'h0, sleeping});
      chk("oe", 32'h0000_0000, {31'h0, oe});
      @(negedge clk);
      sleep = 0;
      print_verdict();
   end
endmodule : sram_burst_port_bench
